//--- logic/mimc_pkg.sv
`default_nettype none
package mimc_pkg;
  // APB geometry
  localparam int APB_AW = 12;
  // Register index as printed, byte address is four times it
  localparam logic [9:0] CFG_IDX = 10'h017;
  localparam logic [11:0] CFG_ADDR = {CFG_IDX, 2'b00};
  localparam logic [11:0] INT_STAT_ADDR = 12'h100;
  localparam logic [11:0] INT_MASK_ADDR = 12'h104;
  localparam logic [11:0] CTRL_ADDR = 12'h108;
  // Field positions of the config/status register
  localparam int B_RX_SHIFT = 12;
  localparam int B_TX_SHIFT_N = 11;
  localparam int B_CLK_SYNC = 10;
  localparam int B_RGMII = 9;
  localparam int B_RMII_TXSH = 8;
  localparam int B_REF50 = 7;
  localparam int B_FIFO_NORM = 6;
  localparam int B_RMII = 5;
  localparam int B_REV10 = 4;
  localparam int B_OVF = 3;
  localparam int B_UNF = 2;
  localparam int B_REC_MODE = 0;
  // Reset values and masks
  localparam logic [15:0] CFG_RST = 16'h0041;
  localparam logic [15:0] CFG_WMASK = 16'h1FF3;
  localparam logic [15:0] EVT_MASK = 16'h000C;
  // Timing
  localparam int SYS_PERIOD_PS = 10000;
  localparam int SHIFT_PS = 3500;
  localparam int SHIFT_CYC = (SHIFT_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int RD_PERIOD_PS = 160000;
  localparam int RD_DIV_CYC = RD_PERIOD_PS / SYS_PERIOD_PS;
  // Elastic buffer geometry
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_DW = 2;
  // Synchronised pins: link clock, valid, data, strap
  localparam int SYNC_W = 5;
  // Interface modes
  typedef enum logic [1:0] {
    IF_MII = 2'b00,
    IF_RMII = 2'b01,
    IF_RGMII = 2'b10
  } mimc_if_mode_t;
  // Receive path states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_FILL = 2'b01,
    RX_DRAIN = 2'b10
  } mimc_rx_st_t;
  // Tolerance in bits for each setting
  function automatic logic [4:0] tol_bits(input logic [1:0] t);
    case (t)
      2'b00: tol_bits = 5'h0E;
      2'b01: tol_bits = 5'h02;
      2'b10: tol_bits = 5'h06;
      default: tol_bits = 5'h0A;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- logic/mimc_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mimc_fifo_if;
  logic wr_en;
  logic [mimc_pkg::FIFO_DW-1:0] wr_data;
  logic rd_en;
  logic flush;
  logic [mimc_pkg::FIFO_DW-1:0] rd_data;
  logic [mimc_pkg::FIFO_AW:0] level;
  logic full;
  logic empty;
  // Controller side
  modport ctl(output wr_en, wr_data, rd_en, flush, input rd_data, level, full, empty);
  // Storage side
  modport mem(input wr_en, wr_data, rd_en, flush, output rd_data, level, full, empty);
endinterface
`default_nettype wire

//--- logic/mimc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module mimc_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins
  input wire logic [mimc_pkg::SYNC_W-1:0] d,
  // Synchronised copies
  output logic rst_n,
  output logic [mimc_pkg::SYNC_W-1:0] q
);
  import mimc_pkg::*;
  typedef struct packed {
    logic [1:0] rst;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } mimc_sync_t;
  mimc_sync_t r_reg;
  mimc_sync_t r_next;
  // Two stages for reset release and for each pin
  always_comb begin
    r_next.rst = {r_reg.rst[0], 1'b1};
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end
  // Registers clear to constants only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign rst_n = r_reg.rst[1];
  assign q = r_reg.s2;
endmodule // mimc_sync
`default_nettype wire

//--- logic/mimc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module mimc_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Buffer access
  mimc_fifo_if.mem f
);
  import mimc_pkg::*;
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][FIFO_DW-1:0] mem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0] cnt;
  } mimc_fifo_t;
  mimc_fifo_t r_reg;
  mimc_fifo_t r_next;
  logic do_wr;
  logic do_rd;
  // Writes ignored when full, reads ignored when empty
  always_comb begin
    r_next = r_reg;
    do_wr = f.wr_en && !f.full;
    do_rd = f.rd_en && !f.empty;
    if (f.flush) begin
      r_next.wp = '0;
      r_next.rp = '0;
      r_next.cnt = '0;
    end else begin
      if (do_wr) begin
        r_next.mem[r_reg.wp] = f.wr_data;
        r_next.wp = r_reg.wp + 1'b1;
      end
      if (do_rd) begin
        r_next.rp = r_reg.rp + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10: r_next.cnt = r_reg.cnt + 1'b1;
        2'b01: r_next.cnt = r_reg.cnt - 1'b1;
        default: r_next.cnt = r_reg.cnt;
      endcase
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign f.rd_data = r_reg.mem[r_reg.rp];
  assign f.level = r_reg.cnt;
  assign f.full = (r_reg.cnt == (FIFO_AW + 1)'(FIFO_DEPTH));
  assign f.empty = (r_reg.cnt == '0);
endmodule // mimc_fifo
`default_nettype wire

//--- logic/mimc_top.sv
// Behaviour
// R1: RGMII receive clock delayed 3.5 ns when set; the code delays it one 10 ns system clock cycle
// R2: Bit 11 low enables RGMII transmit delay
// R3: Bit 10 flags shared MAC/PHY clock reference
// R4: Bit 9 selects RGMII, else bit 5
// R5: Bit 5 picks RMII, clear picks MII
// R6: Bit 8 shifts RMII transmit clock
// R7: Bit 7 reference select, strap default, overridable
// R8: Bit 6 clear bypasses FIFO, 50 MHz out
// R9: Bit 4 picks carrier-valid revision behaviour
// R10: Overflow sets bit 3, read clears
// R11: Underflow sets bit 2, read clears
// R12: Field 1:0 sets elastic tolerance, reset 01
// R13: Minimum tolerance suits standard frames, 50 ppm
// R14: Error flags latched until read returns them
`timescale 1ns/1ns
`default_nettype none
module mimc_top (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [mimc_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // Line side receive pins
  input wire logic LINK_RX_CLK,
  input wire logic LINK_RX_DV,
  input wire logic [1:0] LINK_RXD,
  input wire logic REF_CLOCK_FREQ_STRAP,
  // MAC side receive pins
  output logic MAC_RX_CLK,
  output logic MAC_CRS_DV,
  output logic [1:0] MAC_RXD,
  // Internal transmit clock
  output logic TX_CLK_INT,
  // Mode outputs
  output mimc_pkg::mimc_if_mode_t IF_MODE,
  output logic RX_DELAY_ON,
  output logic TX_DELAY_ON,
  output logic CLK_SYNC_ON,
  output logic REF_CLK_50M,
  output logic RMII_REV_1P0,
  output logic FIFO_BYPASSED,
  output logic [1:0] ELASTIC_TOL
);
  import mimc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cfg;
    logic strap_done;
    logic ref_ovr;
    logic [15:0] int_stat;
    logic [15:0] int_mask;
    logic rec_mode;
    logic [31:0] prdata;
    logic lclk_q;
    logic [SHIFT_CYC:0] rx_pipe;
    logic [SHIFT_CYC:0] tx_pipe;
    mimc_rx_st_t st;
    logic [4:0] div;
    logic crs_dv;
    logic [1:0] rxd;
    logic tog50;
  } mimc_state_t;

  mimc_state_t r_reg;
  mimc_state_t r_next;

  // Synchronised reset and pins
  logic rst_n;
  logic [SYNC_W-1:0] pins;
  logic lclk;
  logic dv;
  logic [1:0] dat;
  logic strap;

  // Decoded configuration
  logic rgmii;
  logic rmii;
  logic rx_shift;
  logic tx_shift;
  logic bypass;
  logic fifo_mode;
  logic lrise;

  // APB phases
  logic setup;
  logic acc;
  logic hit;

  // Events
  logic ovf;
  logic unf;
  logic pulse;
  logic [4:0] start_lvl;

  // Elastic buffer link
  mimc_fifo_if fq ();

  // Reset release and pin synchronisers
  mimc_sync u_sync (
    .clk(SYS_CLK),
    .arst_n(RST_N),
    .d({REF_CLOCK_FREQ_STRAP, LINK_RXD, LINK_RX_DV, LINK_RX_CLK}),
    .rst_n(rst_n),
    .q(pins)
  );

  // Receive elastic buffer
  mimc_fifo u_fifo (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .f(fq)
  );

  // Pin fields
  assign lclk = pins[0];
  assign dv = pins[1];
  assign dat = pins[3:2];
  assign strap = pins[4];

  // Interface mode decode
  always_comb begin
    rgmii = r_reg.cfg[B_RGMII]; // R4
    rmii = !rgmii && r_reg.cfg[B_RMII]; // R5
    rx_shift = rgmii && r_reg.cfg[B_RX_SHIFT]; // R1
    // Inverted sense in RGMII, plain sense in RMII
    tx_shift = (rgmii && !r_reg.cfg[B_TX_SHIFT_N]) // R2
      || (rmii && r_reg.cfg[B_RMII_TXSH]); // R6
    // Bypass only in recovered clock RMII
    bypass = rmii && r_reg.rec_mode && !r_reg.cfg[B_FIFO_NORM]; // R8
    fifo_mode = rmii && !bypass;
    lrise = lclk && !r_reg.lclk_q;
  end

  // APB phase decode
  always_comb begin
    setup = PSEL && !PENABLE;
    acc = PSEL && PENABLE;
    case (PADDR)
      CFG_ADDR: hit = 1'b1;
      INT_STAT_ADDR: hit = 1'b1;
      INT_MASK_ADDR: hit = 1'b1;
      CTRL_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Buffer control and error detection
  always_comb begin
    start_lvl = tol_bits(r_reg.cfg[1:0]) >> 1; // R12
    pulse = (r_reg.div == '0);
    fq.flush = !fifo_mode;
    fq.wr_en = fifo_mode && lrise && dv;
    fq.wr_data = dat;
    fq.rd_en = (r_reg.st == RX_DRAIN) && pulse && !fq.empty;
    // Write into a full buffer
    ovf = fq.wr_en && fq.full; // R10
    // Drained dry while carrier still present
    unf = (r_reg.st == RX_DRAIN) && pulse && fq.empty && dv; // R11
  end

  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.lclk_q = lclk;
    // Clock delay lines, one stage per delay cycle
    r_next.rx_pipe = {r_reg.rx_pipe[SHIFT_CYC-1:0], lclk};
    r_next.tx_pipe = {r_reg.tx_pipe[SHIFT_CYC-1:0], lclk};
    r_next.tog50 = !r_reg.tog50;

    // Catch the reference strap once after reset release
    if (!r_reg.strap_done) begin
      r_next.strap_done = 1'b1;
      if (!r_reg.ref_ovr) begin
        r_next.cfg[B_REF50] = strap; // R7
      end
    end

    // Read data captured in the setup phase
    if (setup && !PWRITE) begin
      case (PADDR)
        CFG_ADDR: r_next.prdata = {16'h0000, r_reg.cfg};
        INT_STAT_ADDR: r_next.prdata = {16'h0000, r_reg.int_stat};
        INT_MASK_ADDR: r_next.prdata = {16'h0000, r_reg.int_mask};
        CTRL_ADDR: r_next.prdata = {31'h00000000, r_reg.rec_mode};
        default: r_next.prdata = 32'h00000000;
      endcase
    end

    // Register writes at the access edge
    if (acc && PWRITE) begin
      case (PADDR)
        CFG_ADDR: begin
          // Status bits are read only
          r_next.cfg = (r_reg.cfg & ~CFG_WMASK) | (PWDATA[15:0] & CFG_WMASK);
          r_next.ref_ovr = 1'b1; // R7
        end
        INT_MASK_ADDR: begin
          r_next.int_mask = PWDATA[15:0] & EVT_MASK;
        end
        CTRL_ADDR: begin
          r_next.rec_mode = PWDATA[B_REC_MODE];
        end
        default: begin
          r_next.int_mask = r_next.int_mask;
        end
      endcase
    end

    // Read clears only the flags it returned
    if (acc && !PWRITE) begin
      case (PADDR)
        CFG_ADDR: begin
          r_next.cfg = r_reg.cfg & ~(r_reg.prdata[15:0] & EVT_MASK); // R14
        end
        INT_STAT_ADDR: begin
          r_next.int_stat = r_reg.int_stat & ~(r_reg.prdata[15:0] & EVT_MASK);
        end
        default: begin
          r_next.int_stat = r_next.int_stat;
        end
      endcase
    end

    // New errors win over a clear in the same cycle
    if (ovf) begin
      r_next.cfg[B_OVF] = 1'b1; // R10
      r_next.int_stat[B_OVF] = 1'b1;
    end
    if (unf) begin
      r_next.cfg[B_UNF] = 1'b1; // R11
      r_next.int_stat[B_UNF] = 1'b1;
    end

    // Read pacing divider, runs only while draining
    if (r_reg.st == RX_DRAIN) begin
      if (r_reg.div == 5'(RD_DIV_CYC - 1)) begin
        r_next.div = '0;
      end else begin
        r_next.div = r_reg.div + 1'b1;
      end
    end else begin
      r_next.div = '0;
    end

    // Receive path
    if (!fifo_mode) begin
      // Direct path for MII, RGMII and bypass
      r_next.st = RX_IDLE;
      r_next.crs_dv = dv;
      r_next.rxd = dat;
    end else begin
      case (r_reg.st)
        RX_IDLE: begin
          // Wait for carrier
          r_next.crs_dv = 1'b0;
          if (fq.wr_en) begin
            r_next.st = RX_FILL;
          end
        end
        RX_FILL: begin
          // Fill to half the tolerance before draining
          if ((fq.level >= start_lvl) || !dv) begin
            r_next.st = RX_DRAIN;
          end
        end
        RX_DRAIN: begin
          if (fq.rd_en) begin
            r_next.rxd = fq.rd_data;
          end
          if (pulse && fq.empty && !dv) begin
            // Last data handed over
            r_next.st = RX_IDLE;
            r_next.crs_dv = 1'b0;
          end else if (dv || r_reg.cfg[B_REV10]) begin
            // Older revision holds valid to the end
            r_next.crs_dv = 1'b1; // R9
          end else if (pulse) begin
            // Newer revision toggles once carrier is gone
            r_next.crs_dv = !r_reg.crs_dv; // R9
          end
        end
        default: begin
          r_next.st = RX_IDLE;
        end
      endcase
    end
  end

  // State register, cleared by the released reset except cfg, which loads CFG_RST
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.cfg <= CFG_RST; // R12
    end else begin
      r_reg <= r_next;
    end
  end

  // Receive clock towards the MAC
  always_comb begin
    if (bypass) begin
      MAC_RX_CLK = r_reg.tog50; // R8
    end else if (rmii) begin
      MAC_RX_CLK = 1'b0;
    end else if (rx_shift) begin
      MAC_RX_CLK = r_reg.rx_pipe[SHIFT_CYC]; // R1
    end else begin
      MAC_RX_CLK = r_reg.rx_pipe[0];
    end
  end

  // Internal transmit clock lags data when shifted
  assign TX_CLK_INT = tx_shift ? r_reg.tx_pipe[SHIFT_CYC] : r_reg.tx_pipe[0]; // R2

  // Receive data and valid
  assign MAC_CRS_DV = r_reg.crs_dv;
  assign MAC_RXD = r_reg.rxd;

  // Mode outputs
  assign IF_MODE = rgmii ? IF_RGMII : (rmii ? IF_RMII : IF_MII); // R4
  assign RX_DELAY_ON = rx_shift;
  assign TX_DELAY_ON = tx_shift;
  assign CLK_SYNC_ON = r_reg.cfg[B_CLK_SYNC]; // R3
  assign REF_CLK_50M = r_reg.cfg[B_REF50];
  assign RMII_REV_1P0 = r_reg.cfg[B_REV10];
  assign FIFO_BYPASSED = bypass;
  assign ELASTIC_TOL = r_reg.cfg[1:0];

  // APB answers with no wait states
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;
  assign PRDATA = r_reg.prdata;

  // Interrupt while any unmasked flag is set
  assign IRQ = |(r_reg.int_stat & r_reg.int_mask);
endmodule // mimc_top
`default_nettype wire

//--- testbench/mimc_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module mimc_link_model (
  // Line side receive pins
  output logic link_clk,
  output logic link_dv,
  output logic [1:0] link_rxd
);
  // Idle line: clock parked low, no carrier
  initial begin
    link_clk = 1'b0;
    link_dv = 1'b0;
    link_rxd = 2'h0;
  end
  // One frame of n dibits; half_ns sets the link rate, so a scenario can run fast or slow
  task automatic send_frame(input int n, input int half_ns);
    for (int i = 0; i < n; i++) begin
      link_rxd = i[1:0];
      link_dv = 1'b1;
      #(half_ns) link_clk = 1'b1;
      #(half_ns) link_clk = 1'b0;
    end
    // Released data shows the inverse of the last dibit, never a stale copy
    link_dv = 1'b0;
    link_rxd = ~link_rxd;
  endtask
endmodule // mimc_link_model
`default_nettype wire

//--- testbench/mimc_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mimc_top_monitor (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Link and MAC side pins
  input wire logic LINK_RX_CLK,
  input wire logic [1:0] LINK_RXD,
  input wire logic MAC_RX_CLK,
  input wire logic [1:0] MAC_RXD,
  input wire logic TX_CLK_INT,
  // Mode outputs
  input wire logic [1:0] IF_MODE,
  input wire logic RX_DELAY_ON,
  input wire logic TX_DELAY_ON,
  input wire logic FIFO_BYPASSED,
  input wire logic [1:0] ELASTIC_TOL
);
  import mimc_pkg::*;
  // All checks on the system clock, quiet in reset
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Steady bypass, steady unshifted transmit, steady plain MII
  sequence s_byp;
    FIFO_BYPASSED [*3];
  endsequence
  sequence s_no_txsh;
    !TX_DELAY_ON [*5];
  endsequence
  sequence s_mii;
    (IF_MODE == IF_MII && !FIFO_BYPASSED) [*5];
  endsequence
  // Steady shifted receive clock, steady shifted transmit clock
  sequence s_rx_sh;
    RX_DELAY_ON [*5];
  endsequence
  sequence s_tx_sh;
    TX_DELAY_ON [*5];
  endsequence
  property p_rx_shift;
    s_rx_sh |-> MAC_RX_CLK == $past(LINK_RX_CLK, 4);
  endproperty
  property p_tx_shift;
    s_tx_sh |-> TX_CLK_INT == $past(LINK_RX_CLK, 4);
  endproperty
  property p_mode_legal;
    IF_MODE != 2'b11;
  endproperty
  property p_rx_delay;
    RX_DELAY_ON |-> IF_MODE == IF_RGMII;
  endproperty
  property p_tx_delay;
    TX_DELAY_ON |-> IF_MODE != IF_MII;
  endproperty
  property p_byp_mode;
    FIFO_BYPASSED |-> IF_MODE == IF_RMII;
  endproperty
  property p_byp_clk;
    s_byp |-> MAC_RX_CLK != $past(MAC_RX_CLK);
  endproperty
  property p_tx_clk;
    s_no_txsh |-> TX_CLK_INT == $past(LINK_RX_CLK, 3);
  endproperty
  property p_mii_clk;
    s_mii |-> MAC_RX_CLK == $past(LINK_RX_CLK, 3);
  endproperty
  property p_mii_data;
    s_mii |-> MAC_RXD == $past(LINK_RXD, 3);
  endproperty
  property p_tol_rst;
    $rose(RST_N) |-> ELASTIC_TOL == 2'b01;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal interface mode");
  a_rx_delay: assert property (p_rx_delay) else $error("receive shift outside RGMII");
  a_tx_delay: assert property (p_tx_delay) else $error("transmit shift in MII");
  a_byp_mode: assert property (p_byp_mode) else $error("bypass outside RMII");
  a_byp_clk: assert property (p_byp_clk) else $error("bypass clock not toggling");
  a_tx_clk: assert property (p_tx_clk) else $error("transmit clock delay wrong");
  a_mii_clk: assert property (p_mii_clk) else $error("MII receive clock delay wrong");
  a_mii_data: assert property (p_mii_data) else $error("MII receive data delay wrong");
  a_tol_rst: assert property (p_tol_rst) else $error("tolerance reset value wrong");
  a_rx_shift: assert property (p_rx_shift) else $error("shifted receive clock delay wrong");
  a_tx_shift: assert property (p_tx_shift) else $error("shifted transmit clock delay wrong");
endmodule // mimc_top_monitor
bind mimc_top mimc_top_monitor u_mon (.SYS_CLK, .RST_N, .LINK_RX_CLK, .LINK_RXD, .MAC_RX_CLK, .MAC_RXD,
  .TX_CLK_INT, .IF_MODE, .RX_DELAY_ON, .TX_DELAY_ON, .FIFO_BYPASSED, .ELASTIC_TOL);
`default_nettype wire

//--- testbench/mimc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module mimc_top_test;
  import mimc_pkg::*;
  // Design pins, named as the ports
  logic SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, REF_CLOCK_FREQ_STRAP;
  logic LINK_RX_CLK, LINK_RX_DV, MAC_RX_CLK, MAC_CRS_DV, TX_CLK_INT, RX_DELAY_ON, TX_DELAY_ON;
  logic CLK_SYNC_ON, REF_CLK_50M, RMII_REV_1P0, FIFO_BYPASSED;
  logic [1:0] LINK_RXD, MAC_RXD, ELASTIC_TOL;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  mimc_if_mode_t IF_MODE;
  logic err;
  int n_fail, comparisons, falls;
  mimc_top dut (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .IRQ, .LINK_RX_CLK, .LINK_RX_DV, .LINK_RXD, .REF_CLOCK_FREQ_STRAP, .MAC_RX_CLK, .MAC_CRS_DV, .MAC_RXD,
    .TX_CLK_INT, .IF_MODE, .RX_DELAY_ON, .TX_DELAY_ON, .CLK_SYNC_ON, .REF_CLK_50M, .RMII_REV_1P0,
    .FIFO_BYPASSED, .ELASTIC_TOL);
  mimc_link_model link (.link_clk(LINK_RX_CLK), .link_dv(LINK_RX_DV), .link_rxd(LINK_RXD));
  // 100 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Count carrier-valid falls for the revision scenario
  always @(posedge SYS_CLK) begin
    if ($fell(MAC_CRS_DV)) begin
      falls++;
    end
  end
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the completing edge, then let updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask
  // Reset values, strap capture, unmapped access
  task automatic t_reset;
    check(ELASTIC_TOL, 2'b01);
    check(IF_MODE, IF_MII);
    apb(1'b0, CFG_ADDR, 32'h0);
    check(rd, 32'h000000C1);
    apb(1'b0, 12'h200, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
  endtask
  // Mode table: write data, expected mode, receive shift, transmit shift
  task automatic t_modes;
    logic [19:0] tbl [6] = '{20'h1202B, 20'h0A008, 20'h01215, 20'h10204, 20'h00010, 20'h049F0};
    logic [15:0] w;
    foreach (tbl[i]) begin
      w = tbl[i][19:4];
      apb(1'b1, CFG_ADDR, {16'h0, w});
      apb(1'b0, CFG_ADDR, 32'h0);
      check(rd, {16'h0, w & CFG_WMASK});
      check(IF_MODE, tbl[i][3:2]);
      check(RX_DELAY_ON, tbl[i][1]);
      check(TX_DELAY_ON, tbl[i][0]);
      check({CLK_SYNC_ON, REF_CLK_50M, RMII_REV_1P0, ELASTIC_TOL}, {w[10], w[7], w[4], w[1:0]});
    end
    $display("test modes done");
  endtask
  // Recovered-clock bypass drives a half-rate clock
  task automatic t_bypass;
    logic v;
    apb(1'b1, CTRL_ADDR, 32'h1);
    apb(1'b1, CFG_ADDR, 32'h21);
    check(FIFO_BYPASSED, 1'b1);
    repeat (3) begin
      @(posedge SYS_CLK);
      #1;
      v = MAC_RX_CLK;
      @(posedge SYS_CLK);
      #1;
      check(MAC_RX_CLK, !v);
    end
    apb(1'b1, CFG_ADDR, 32'h61);
    check(FIFO_BYPASSED, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h0);
    $display("test bypass done");
  endtask
  // Carrier-valid at frame end: one fall for 1.0, toggling for 1.2
  task automatic t_rev(input logic r10);
    apb(1'b1, CFG_ADDR, {27'h3, r10, 4'h0});
    falls = 0;
    link.send_frame(20, 80);
    repeat (400) @(posedge SYS_CLK);
    check(falls >= 1, 1'b1);
    check(falls > 1, !r10);
    check(MAC_RXD, 2'h3);
    $display("test revision done");
  endtask
  // Off-rate frame raises a flag; mask, interrupt, read clear
  task automatic t_flag(input int n, input int half, input logic [31:0] fl, input logic [31:0] tol);
    apb(1'b1, CFG_ADDR, 32'h60 | tol);
    apb(1'b0, CFG_ADDR, 32'h0);
    apb(1'b0, INT_STAT_ADDR, 32'h0);
    apb(1'b1, INT_MASK_ADDR, 32'h0);
    link.send_frame(n, half);
    repeat (300) @(posedge SYS_CLK);
    check(IRQ, 1'b0);
    apb(1'b1, INT_MASK_ADDR, fl);
    check(IRQ, 1'b1);
    apb(1'b0, INT_STAT_ADDR, 32'h0);
    check(rd & EVT_MASK, fl);
    check(IRQ, 1'b0);
    apb(1'b0, CFG_ADDR, 32'h0);
    check(rd & EVT_MASK, fl);
    apb(1'b0, CFG_ADDR, 32'h0);
    check(rd & EVT_MASK, 32'h0);
    $display("test flag %0h done", fl);
  endtask
  // Direct path in MII or RGMII: valid follows the pins, the released dibit stands after the frame
  task automatic t_direct(input logic [15:0] w);
    apb(1'b1, CFG_ADDR, {16'h0, w});
    fork
      link.send_frame(7, 80);
      begin
        repeat (40) @(posedge SYS_CLK);
        #1;
        check(MAC_CRS_DV, 1'b1);
      end
    join
    repeat (5) @(posedge SYS_CLK);
    #1;
    check({MAC_CRS_DV, MAC_RXD}, 3'b001);
    $display("test direct %0h done", w);
  endtask
  // Mid-run reset with the strap low: bit 7 follows the strap again
  task automatic t_strap;
    @(posedge SYS_CLK);
    REF_CLOCK_FREQ_STRAP <= 1'b0;
    RST_N <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge SYS_CLK);
    check(ELASTIC_TOL, 2'b01);
    check(IRQ, 1'b0);
    apb(1'b0, CFG_ADDR, 32'h0);
    check(rd, 32'h00000041);
    $display("test strap done");
  endtask
  // Verdict
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 3100 cycles
  initial begin
    #400000;
    n_fail++;
    finish_test;
  end
  // Main sequence
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    REF_CLOCK_FREQ_STRAP = 1'b1;
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge SYS_CLK);
    t_reset;
    t_modes;
    t_bypass;
    t_rev(1'b1);
    t_rev(1'b0);
    t_flag(40, 40, 32'h8, 32'h0);
    t_flag(10, 160, 32'h4, 32'h1);
    t_direct(16'h0041);
    t_direct(16'h1241);
    t_strap;
    finish_test;
  end
endmodule // mimc_top_test
`default_nettype wire
